/* logic/sbcwd_pkg.sv */
/*
 * Constants, types and register layout for the watchdog / bus control bank.
 * Assumes a single 125 MHz clock and an SPI master on the far side.
 */
package sbcwd_pkg;
	// ==========================================================
	// Register addresses (7-bit SPI address)
	localparam logic [6:0] SBCWD_ADDR_WDOG = 7'h03;
	localparam logic [6:0] SBCWD_ADDR_CAN = 7'h04;
	localparam logic [6:0] SBCWD_ADDR_PEAK = 7'h05;

	// ==========================================================
	// Field positions
	localparam int SBCWD_WD_CHECKSUM_BIT = 7;
	localparam int SBCWD_WD_STOP_DIS_BIT = 6;
	localparam int SBCWD_WD_TYPE_BIT = 5;
	localparam int SBCWD_WD_BUS_WAKE_BIT = 4;
	localparam int SBCWD_WD_PERIOD_MSB = 2;
	localparam int SBCWD_PEAK_BIT = 5;

	// ==========================================================
	// Reset, restart and fail-safe values
	localparam logic [7:0] SBCWD_WDOG_RST = 8'h14;
	localparam logic [7:0] SBCWD_CAN_RST = 8'h00;
	localparam logic [7:0] SBCWD_PEAK_RST = 8'h00;
	localparam logic [2:0] SBCWD_WD_PERIOD_RESTART = 3'h4;
	localparam logic [1:0] SBCWD_CAN_FAILSAFE = 2'h1;
	localparam logic [7:0] SBCWD_EXT_WAKE_FAILSAFE = 8'h07;
	localparam logic [7:0] SBCWD_EXT_WAKE_FAILSAFE_MASK = 8'h4f;

	// ==========================================================
	// SPI frame
	localparam logic [4:0] SBCWD_FRAME_BITS = 5'h10;
	localparam logic [4:0] SBCWD_ADDR_BITS = 5'h08;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		SBCWD_CAN_OFF,
		SBCWD_CAN_WAKE,
		SBCWD_CAN_RX_ONLY,
		SBCWD_CAN_NORMAL
	} sbcwd_can_mode_t;

	typedef enum logic [2:0] {
		SBCWD_MODE_INIT,
		SBCWD_MODE_NORMAL,
		SBCWD_MODE_STOP,
		SBCWD_MODE_SLEEP,
		SBCWD_MODE_RESTART,
		SBCWD_MODE_FAILSAFE
	} sbcwd_mode_t;

	typedef struct packed {
		logic wr;
		logic [6:0] addr;
		logic [7:0] data;
	} sbcwd_frame_t;

	typedef struct packed {
		logic checksum;
		logic stop_wdog_disable_low;
		logic wdog_type_select;
		logic wdog_start_on_bus_wake;
		logic [2:0] wdog_period_select;
	} sbcwd_wdog_t;

	// Hardware-side events in the clk domain: one-cycle pulses, plus the CAN mode values that go with them
	typedef struct packed {
		logic soft_reset;
		logic restart;
		logic failsafe;
		logic can_hw_wr;
		sbcwd_can_mode_t can_hw_mode;
		sbcwd_can_mode_t can_restart_mode;
	} sbcwd_events_t;
endpackage

/* logic/sbcwd_spi.sv */
/*
 * SPI slave front end: 16-bit frames, MSB first, mode 0.
 * Assumes the pins are asynchronous to clk and slow against 125 MHz.
 */
module sbcwd_spi
	import sbcwd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic spi_sck,
	input wire logic spi_csn,
	input wire logic spi_mosi,
	input wire logic [7:0] rd_data,
	output logic [6:0] rd_addr,
	output logic spi_miso,
	output logic spi_miso_oe,
	output logic frame_valid,
	output sbcwd_pkg::sbcwd_frame_t frame
);
	typedef struct packed {
		logic [2:0] sck_s;
		logic [2:0] csn_s;
		logic [2:0] mosi_s;
		logic sck_f;
		logic csn_f;
		logic [4:0] cnt;
		logic [15:0] sh;
		logic [7:0] tx;
		logic miso;
		logic oe;
		logic done;
		sbcwd_frame_t frame;
	} sbcwd_spi_st_t;

	sbcwd_spi_st_t q;
	sbcwd_spi_st_t d;
	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	logic cs_fall;

	// ==========================================================
	// Pin filtering and shifting
	always_comb
	begin
		d = q;
		d.done = 1'b0;
		d.sck_s = {q.sck_s[1:0], spi_sck};
		d.csn_s = {q.csn_s[1:0], spi_csn};
		d.mosi_s = {q.mosi_s[1:0], spi_mosi};
		// A level counts only once stages two and three agree
		if (q.sck_s[2] == q.sck_s[1])
			d.sck_f = q.sck_s[2];
		if (q.csn_s[2] == q.csn_s[1])
			d.csn_f = q.csn_s[2];
		sck_rise = d.sck_f && !q.sck_f;
		sck_fall = !d.sck_f && q.sck_f;
		cs_fall = !d.csn_f && q.csn_f;
		cs_rise = d.csn_f && !q.csn_f;
		if (cs_fall)
		begin
			d.cnt = '0;
			d.miso = 1'b0;
			d.oe = 1'b1;
		end
		else if (cs_rise)
		begin
			d.oe = 1'b0;
			d.miso = 1'b0;
			// Short or long frames are dropped whole
			if (q.cnt == SBCWD_FRAME_BITS)
			begin
				d.done = 1'b1;
				d.frame = q.sh;
			end
		end
		else if (!q.csn_f)
		begin
			if (sck_rise && q.cnt != SBCWD_FRAME_BITS + 5'h01)
			begin
				d.sh = {q.sh[14:0], q.mosi_s[2]};
				d.cnt = q.cnt + 5'h01;
			end
			if (sck_fall && q.cnt == SBCWD_ADDR_BITS)
			begin
				// Data goes out before any write lands: old contents
				d.miso = rd_data[7];
				d.tx = {rd_data[6:0], 1'b0};
			end
			else if (sck_fall && q.cnt > SBCWD_ADDR_BITS)
			begin
				d.miso = q.tx[7];
				d.tx = {q.tx[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.sck_s <= 3'h0;
			q.csn_s <= 3'h7;
			q.csn_f <= 1'b1;
		end
		else
			q <= d;
	end

	assign rd_addr = q.sh[6:0];
	assign spi_miso = q.miso;
	assign spi_miso_oe = q.oe;
	assign frame_valid = q.done;
	assign frame = q.frame;
endmodule

/* logic/sbcwd_regs.sv */
/*
 * Watchdog, CAN mode and active-peak control registers behind SPI.
 * Holds the three host-visible control bytes and the fail-safe wake pattern.
 * Assumes mode and event inputs come from logic on the same clock.
 * Assumes the wake control bank applies value and mask on the reload pulse,
 * and that the second Stop disable bit is held there as a level.
 */
// Overview of operation
// - Bit 6 requests watchdog off in Stop
// - Second Stop disable bit lives elsewhere
// - Bit 5 picks time-out or window watchdog
// - Bit 4 restarts watchdog after CAN wake
// - Watchdog reg resets 0x14, restart partial
// - Reserved bits always read zero
// - CAN reg zero on reset, restart cause-dependent
// - Bit 5 selects peak current threshold
// - Threshold writable in Init and Normal
// - Stop mode: threshold write silently ignored
// - Peak reg zero on reset, restart keeps bit5
// - Fail-safe reloads wake source patterns
// - Write returns previously programmed contents
module sbcwd_regs
	import sbcwd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic spi_sck,
	input wire logic spi_csn,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	input sbcwd_pkg::sbcwd_mode_t sbc_mode,
	input sbcwd_pkg::sbcwd_events_t events,
	input wire logic stop_wdog_disable_high,
	output sbcwd_pkg::sbcwd_wdog_t wdog_cfg,
	output logic wdog_parity_ok,
	output logic wdog_off_in_stop,
	output sbcwd_pkg::sbcwd_can_mode_t can_mode,
	output logic active_peak_threshold_sel,
	output logic ext_wake_reload,
	output logic [7:0] ext_wake_reload_value,
	output logic [7:0] ext_wake_reload_mask
);
	typedef struct packed {
		sbcwd_wdog_t wd;
		sbcwd_can_mode_t can;
		logic peak;
		logic parity_ok;
		logic off_in_stop;
		logic reload;
		logic [7:0] wake_val;
		logic [7:0] wake_mask;
	} sbcwd_regs_st_t;

	sbcwd_regs_st_t q;
	sbcwd_regs_st_t d;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	logic frame_valid;
	sbcwd_frame_t frame;
	logic [7:0] wd_img;
	logic [7:0] can_img;
	logic [7:0] peak_img;
	logic ev_soft;
	logic ev_fail;
	logic ev_restart;
	logic wr_wdog;
	logic wr_can;
	logic wr_peak;
	logic peak_open;
	logic wr_parity_even;

	sbcwd_spi u_spi (
		.clk(clk),
		.rst_n(rst_n),
		.spi_sck(spi_sck),
		.spi_csn(spi_csn),
		.spi_mosi(spi_mosi),
		.rd_data(rd_data),
		.rd_addr(rd_addr),
		.spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe),
		.frame_valid(frame_valid),
		.frame(frame)
	);

	// ==========================================================
	// Read images
	always_comb
	begin
		wd_img = {q.wd.checksum, q.wd.stop_wdog_disable_low, q.wd.wdog_type_select,
			q.wd.wdog_start_on_bus_wake, 1'b0, q.wd.wdog_period_select};
		can_img = {6'h00, q.can};
		peak_img = 8'h00;
		peak_img[SBCWD_PEAK_BIT] = q.peak;
		case (rd_addr)
			SBCWD_ADDR_WDOG: rd_data = wd_img;
			SBCWD_ADDR_CAN: rd_data = can_img;
			SBCWD_ADDR_PEAK: rd_data = peak_img;
			default: rd_data = 8'h00;
		endcase
	end

	// ==========================================================
	// Event priority: soft reset over fail-safe over restart
	// A host write in the same cycle as soft reset, fail-safe or restart is lost
	always_comb
	begin
		ev_soft = events.soft_reset;
		ev_fail = events.failsafe && !events.soft_reset;
		ev_restart = events.restart && !events.failsafe && !events.soft_reset;
	end

	// ==========================================================
	// Write decode: one strobe per register, unmapped addresses dropped
	always_comb
	begin
		wr_wdog = 1'b0;
		wr_can = 1'b0;
		wr_peak = 1'b0;
		if (frame_valid && frame.wr)
		begin
			case (frame.addr)
				SBCWD_ADDR_WDOG: wr_wdog = 1'b1;
				SBCWD_ADDR_CAN: wr_can = 1'b1;
				SBCWD_ADDR_PEAK: wr_peak = 1'b1;
				default: wr_wdog = 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Mode gate for the threshold bit
	always_comb
	begin
		case (sbc_mode)
			SBCWD_MODE_INIT: peak_open = 1'b1;
			SBCWD_MODE_NORMAL: peak_open = 1'b1;
			// Stop drops the write with no fault and no interrupt
			default: peak_open = 1'b0;
		endcase
	end

	// ==========================================================
	// Parity of the incoming byte, reported but never enforced
	assign wr_parity_even = ~^frame.data;

	// ==========================================================
	// Update, in priority: soft reset, fail-safe, restart, SPI, hardware
	always_comb
	begin
		d = q;
		d.reload = 1'b0;
		if (ev_soft)
		begin
			d.wd = sbcwd_wdog_t'({SBCWD_WDOG_RST[7:4], SBCWD_WDOG_RST[2:0]});
			d.can = sbcwd_can_mode_t'(SBCWD_CAN_RST[1:0]);
			d.peak = SBCWD_PEAK_RST[SBCWD_PEAK_BIT];
			d.parity_ok = ~^SBCWD_WDOG_RST;
		end
		else if (ev_fail)
		begin
			// Leave CAN wake capable so the part can still be woken
			d.can = sbcwd_can_mode_t'(SBCWD_CAN_FAILSAFE);
			d.reload = 1'b1;
		end
		else if (ev_restart)
		begin
			d.wd.wdog_period_select = SBCWD_WD_PERIOD_RESTART;
			d.wd.stop_wdog_disable_low = 1'b0;
			d.can = events.can_restart_mode;
		end
		else if (wr_wdog)
		begin
			// Bit 3 is not stored, so it stays zero
			d.wd.checksum = frame.data[SBCWD_WD_CHECKSUM_BIT];
			d.wd.stop_wdog_disable_low = frame.data[SBCWD_WD_STOP_DIS_BIT];
			d.wd.wdog_type_select = frame.data[SBCWD_WD_TYPE_BIT];
			d.wd.wdog_start_on_bus_wake = frame.data[SBCWD_WD_BUS_WAKE_BIT];
			d.wd.wdog_period_select = frame.data[SBCWD_WD_PERIOD_MSB:0];
			// Host owns the checksum; we only report it
			d.parity_ok = wr_parity_even;
		end
		else if (wr_can)
			d.can = sbcwd_can_mode_t'(frame.data[1:0]);
		else if (wr_peak && peak_open)
			d.peak = frame.data[SBCWD_PEAK_BIT];
		else if (events.can_hw_wr)
			d.can = events.can_hw_mode;
		// Both disable bits must be set; one bit alone cannot stop it
		d.off_in_stop = d.wd.stop_wdog_disable_low && stop_wdog_disable_high;
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.wd <= sbcwd_wdog_t'({SBCWD_WDOG_RST[7:4], SBCWD_WDOG_RST[2:0]});
			q.can <= SBCWD_CAN_OFF;
			q.peak <= 1'b0;
			q.parity_ok <= 1'b1;
			// Wake pattern sits in flops so every output leaves a register
			q.wake_val <= SBCWD_EXT_WAKE_FAILSAFE;
			q.wake_mask <= SBCWD_EXT_WAKE_FAILSAFE_MASK;
		end
		else
			q <= d;
	end

	// ==========================================================
	// Outputs
	assign wdog_cfg = q.wd;
	assign wdog_parity_ok = q.parity_ok;
	assign wdog_off_in_stop = q.off_in_stop;
	assign can_mode = q.can;
	assign active_peak_threshold_sel = q.peak;
	assign ext_wake_reload = q.reload;
	assign ext_wake_reload_value = q.wake_val;
	assign ext_wake_reload_mask = q.wake_mask;
endmodule

/* testbench/sbcwd_regs_asserts.sv */
/* Checker on the control bank outputs.
 Assumes it is bound to sbcwd_regs, which has one clock domain. */
module sbcwd_regs_chk
	import sbcwd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input sbcwd_pkg::sbcwd_mode_t sbc_mode,
	input sbcwd_pkg::sbcwd_events_t events,
	input wire logic stop_wdog_disable_high,
	input sbcwd_pkg::sbcwd_wdog_t wdog_cfg,
	input wire logic wdog_off_in_stop,
	input sbcwd_pkg::sbcwd_can_mode_t can_mode,
	input wire logic active_peak_threshold_sel,
	input wire logic ext_wake_reload
);
	timeunit 1ns;
	timeprecision 1ps;
	logic fs;
	logic rs;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Priority: soft reset, then fail-safe, then restart
	assign fs = events.failsafe & ~events.soft_reset;
	assign rs = events.restart & ~fs & ~events.soft_reset;
	// ==========================================================
	// Assertions
	chk_wd_por: assert property (events.soft_reset |=> wdog_cfg == 7'h0c)
		else $error("watchdog cfg not at reset value");
	chk_wd_restart: assert property (rs |=> wdog_cfg.wdog_period_select == 3'h4
		&& !wdog_cfg.stop_wdog_disable_low && $stable(wdog_cfg.wdog_type_select))
		else $error("watchdog restart value wrong");
	chk_can_restart: assert property (rs |=> can_mode == $past(events.can_restart_mode))
		else $error("can mode restart value wrong");
	chk_peak_restart: assert property (rs |=> $stable(active_peak_threshold_sel))
		else $error("peak select lost on restart");
	chk_peak_stop: assert property (sbc_mode == SBCWD_MODE_STOP && !events.soft_reset
		|=> $stable(active_peak_threshold_sel))
		else $error("peak select changed in stop");
	chk_fs_can: assert property (fs |=> can_mode == SBCWD_CAN_WAKE)
		else $error("can mode not wake capable after fail-safe");
	chk_fs_pulse: assert property (fs |=> ext_wake_reload ##1 !ext_wake_reload)
		else $error("wake reload pulse wrong");
	chk_stop_off: assert property (1'b1 |=> wdog_off_in_stop ==
		(wdog_cfg.stop_wdog_disable_low & $past(stop_wdog_disable_high)))
		else $error("stop disable combination wrong");
endmodule

bind sbcwd_regs sbcwd_regs_chk sbcwd_regs_chk_inst (.clk(clk), .rst_n(rst_n),
	.sbc_mode(sbc_mode), .events(events), .stop_wdog_disable_high(stop_wdog_disable_high),
	.wdog_cfg(wdog_cfg), .wdog_off_in_stop(wdog_off_in_stop), .can_mode(can_mode),
	.active_peak_threshold_sel(active_peak_threshold_sel), .ext_wake_reload(ext_wake_reload));

/* testbench/sbcwd_host.sv */
/* Host model: SPI master, mode 0, 16-bit frames, MSB first.
 Assumes the caller enters xfer between clk edges. */
module sbcwd_host (
	input wire logic clk,
	input wire logic spi_miso,
	output logic spi_sck,
	output logic spi_csn,
	output logic spi_mosi
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		spi_sck = 1'b0;
		spi_csn = 1'b1;
		spi_mosi = 1'b0;
	end
	// Half period of 5 clk, above the 4 clk the sampler needs
	task automatic xfer(input logic [15:0] f, output logic [7:0] r);
		r = 8'h00;
		@(negedge clk);
		spi_csn = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			spi_mosi = f[i];
			repeat (5) @(negedge clk);
			spi_sck = 1'b1;
			if (i < 8)
				r[i] = spi_miso;
			repeat (5) @(negedge clk);
			spi_sck = 1'b0;
		end
		repeat (5) @(negedge clk);
		spi_csn = 1'b1;
		// Idle data line must not echo the last bit
		spi_mosi = ~spi_mosi;
		repeat (12) @(negedge clk);
	endtask
endmodule

/* testbench/tb.sv */
/* Top bench: host model, control bank, expected values from the bench.
 Assumes the checker binds itself to the bank. */
module tb
	import sbcwd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, sck, csn, mosi, miso, oe, hi, off, pok, pk, rl;
	sbcwd_mode_t mode;
	sbcwd_events_t ev, e;
	sbcwd_wdog_t cfg;
	sbcwd_can_mode_t can;
	logic [7:0] r, w, d, rv, rm;
	int fails, cmp_count;
	sbcwd_host host_inst (.clk(clk), .spi_miso(miso), .spi_sck(sck), .spi_csn(csn),
		.spi_mosi(mosi));
	sbcwd_regs sbcwd_regs_inst (.clk(clk), .rst_n(rst_n), .spi_sck(sck), .spi_csn(csn),
		.spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe), .sbc_mode(mode), .events(ev),
		.stop_wdog_disable_high(hi), .wdog_cfg(cfg), .wdog_parity_ok(pok),
		.wdog_off_in_stop(off), .can_mode(can), .active_peak_threshold_sel(pk),
		.ext_wake_reload(rl), .ext_wake_reload_value(rv), .ext_wake_reload_mask(rm));
	// ==========================================================
	// Expectations and helpers
	function automatic logic [7:0] even(input logic [7:0] v);
		return {^v[6:0], v[6:0]};
	endfunction
	function automatic logic [7:0] wd_restart(input logic [7:0] v);
		return (v & 8'hb0) | 8'h04;
	endfunction
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
		cmp_count++;
		if (s !== x)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, x, s);
		end
	endtask
	// Writes compare the returned byte with the old contents
	task automatic xf(input logic wr, input logic [6:0] a, input logic [7:0] v,
		input logic [7:0] x);
		host_inst.xfer({wr, a, v}, r);
		chk("spi", r, x);
		chk("miso enable", 8'(oe), 8'h00);
	endtask
	task automatic pulse(input sbcwd_events_t p);
		@(negedge clk);
		ev = p;
		@(negedge clk);
		ev = '0;
	endtask
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========================================================
	// Clock, watchdog, tests
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		#200000;
		fails++;
		close_out();
	end
	initial
	begin
		rst_n = 1'b0;
		mode = SBCWD_MODE_INIT;
		ev = '0;
		hi = 1'b0;
		fails = 0;
		cmp_count = 0;
		void'($urandom(45));
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (5) @(negedge clk);
		xf(0, SBCWD_ADDR_WDOG, 8'h00, 8'h14);
		xf(0, SBCWD_ADDR_CAN, 8'h00, 8'h00);
		xf(0, 7'h7f, 8'h00, 8'h00);
		w = 8'h14;
		for (int i = 0; i < 6; i++)
		begin
			d = even(8'($urandom) & 8'h77);
			if (i == 5)
				d[7] = ~d[7];
			xf(1, SBCWD_ADDR_WDOG, d, w);
			w = d;
			chk("parity", 8'(pok), 8'(i != 5));
			chk("cfg", 8'(cfg), {1'b0, d[7:4], d[2:0]});
		end
		xf(1, SBCWD_ADDR_WDOG, w | 8'h08, w);
		xf(0, SBCWD_ADDR_WDOG, 8'h00, w);
		hi = 1'b1;
		repeat (3) @(negedge clk);
		chk("stop off", 8'(off), 8'(w[6]));
		hi = 1'b0;
		for (int m = 0; m < 4; m++)
		begin
			xf(1, SBCWD_ADDR_CAN, 8'hfc | 8'(m), 8'((m + 3) % 4 * (m > 0)));
			chk("can", 8'(can), 8'(m));
		end
		xf(0, SBCWD_ADDR_CAN, 8'h00, 8'h03);
		e = '0;
		e.can_hw_wr = 1'b1;
		e.can_hw_mode = SBCWD_CAN_RX_ONLY;
		pulse(e);
		xf(0, SBCWD_ADDR_CAN, 8'h00, 8'h02);
		xf(1, SBCWD_ADDR_PEAK, 8'hff, 8'h00);
		xf(0, SBCWD_ADDR_PEAK, 8'h00, 8'h20);
		mode = SBCWD_MODE_NORMAL;
		xf(1, SBCWD_ADDR_PEAK, 8'h00, 8'h20);
		xf(1, SBCWD_ADDR_PEAK, 8'h20, 8'h00);
		mode = SBCWD_MODE_STOP;
		xf(1, SBCWD_ADDR_PEAK, 8'h00, 8'h20);
		chk("peak", 8'(pk), 8'h01);
		mode = SBCWD_MODE_NORMAL;
		e = '0;
		e.restart = 1'b1;
		e.can_restart_mode = sbcwd_can_mode_t'($urandom % 4);
		pulse(e);
		xf(0, SBCWD_ADDR_WDOG, 8'h00, wd_restart(w));
		xf(0, SBCWD_ADDR_CAN, 8'h00, 8'(e.can_restart_mode));
		xf(0, SBCWD_ADDR_PEAK, 8'h00, 8'h20);
		e = '0;
		e.failsafe = 1'b1;
		pulse(e);
		chk("reload", 8'(rl), 8'h01);
		@(negedge clk);
		chk("reload end", 8'(rl), 8'h00);
		chk("wake value", rv, 8'h07);
		chk("wake mask", rm, 8'h4f);
		xf(0, SBCWD_ADDR_CAN, 8'h00, 8'h01);
		e = '0;
		e.soft_reset = 1'b1;
		pulse(e);
		xf(0, SBCWD_ADDR_WDOG, 8'h00, 8'h14);
		xf(0, SBCWD_ADDR_PEAK, 8'h00, 8'h00);
		xf(0, SBCWD_ADDR_CAN, 8'h00, 8'h00);
		close_out();
	end
endmodule
